// ---- verilog/mpcr_regs.v ----
// Control register bank of the paravirtual I/O device.
`timescale 1ns/1ps
`include "mpcr_defines.vh"

module mpcr_regs
(
  // Clock, reset and clock enable.
  input  wire                                  core_clk,
  input  wire                                  rst,
  input  wire                                  core_ce,
  // Register access port.
  input  wire [`MPCR_ADDR_W-1:0]               reg_addr,
  input  wire                                  reg_wr,
  input  wire                                  reg_rd,
  input  wire [3:0]                            reg_be,
  input  wire [`MPCR_DATA_W-1:0]               reg_wdata,
  output reg  [`MPCR_DATA_W-1:0]               reg_rdata_q,
  output reg                                   reg_rvalid_q,
  // Feature words.
  input  wire [`MPCR_FEAT_W-1:0]               offered_features_in,
  output reg  [`MPCR_FEAT_W-1:0]               accepted_features_q,
  // Queue engine side.
  output reg  [`MPCR_NUM_Q-1:0]                queue_enables_q,
  output reg                                   kick_valid_q,
  output reg  [`MPCR_DATA_W-1:0]               kick_queue_q,
  input  wire                                  eng_rd,
  input  wire [`MPCR_QIDX_W-1:0]               eng_queue,
  input  wire [`MPCR_QF_W-1:0]                 eng_field,
  output wire [`MPCR_DATA_W-1:0]               eng_data_q,
  input  wire                                  used_buffer_evt,
  // Device-side configuration writes.
  input  wire                                  cfg_dev_wr,
  input  wire [3:0]                            cfg_dev_be,
  input  wire [`MPCR_CFG_IDX_W-1:0]            cfg_dev_idx,
  input  wire [`MPCR_DATA_W-1:0]               cfg_dev_wdata,
  // Status and interrupt.
  output reg  [`MPCR_DATA_W-1:0]               device_status_q,
  output reg                                   dev_reset_pulse_q,
  output reg                                   irq_q
);

  localparam SRC_IMM = 1'b0;
  localparam SRC_CFG = 1'b1;

  reg  [`MPCR_DATA_W-1:0]  off_sel_q;
  reg  [`MPCR_DATA_W-1:0]  acc_sel_q;
  reg  [`MPCR_DATA_W-1:0]  qsel_q;
  reg  [`MPCR_EVT_W-1:0]   evt_q;
  reg  [`MPCR_EVT_W-1:0]   evt_d;
  reg  [`MPCR_DATA_W-1:0]  version_q;
  reg                      rd_p1_q;
  reg                      rd_src_q;
  reg  [`MPCR_DATA_W-1:0]  rd_imm_q;
  reg  [`MPCR_DATA_W-1:0]  rd_imm_d;
  reg                      qf_hit;
  reg  [`MPCR_QF_W-1:0]    qf_code;
  wire [`MPCR_DATA_W-1:0]  cfg_rdata_q;
  wire                     ctl_wr;
  wire                     ctl_rd;
  wire                     cfg_wr;
  wire                     cfg_rd;
  wire                     q_exists;
  wire [`MPCR_QIDX_W-1:0]  qidx;
  wire                     soft_rst;
  wire [`MPCR_EVT_W-1:0]   evt_set;
  wire [`MPCR_EVT_W-1:0]   evt_clr;

  ////////////////////////////////////////////////////////////////////
  // Address decode.
  assign ctl_wr   = reg_wr && !reg_addr[`MPCR_CFG_BIT];
  assign ctl_rd   = reg_rd && !reg_addr[`MPCR_CFG_BIT];
  assign cfg_wr   = reg_wr && reg_addr[`MPCR_CFG_BIT];
  assign cfg_rd   = reg_rd && reg_addr[`MPCR_CFG_BIT];
  assign q_exists = (qsel_q < `MPCR_NUM_Q);
  assign qidx     = qsel_q[`MPCR_QIDX_W-1:0];
  assign soft_rst = core_ce && ctl_wr && (reg_addr == `MPCR_OFF_STATUS)
                    && (reg_wdata == {`MPCR_DATA_W{1'b0}});

  // Maps a per-queue register offset onto its storage field.
  always @*
  begin
    qf_hit  = 1'b1;
    qf_code = `MPCR_QF_SIZE;
    case (reg_addr)
      `MPCR_OFF_QSIZE:   qf_code = `MPCR_QF_SIZE;
      `MPCR_OFF_DESC_LO: qf_code = `MPCR_QF_DESC_LO;
      `MPCR_OFF_DESC_HI: qf_code = `MPCR_QF_DESC_HI;
      `MPCR_OFF_DRV_LO:  qf_code = `MPCR_QF_DRV_LO;
      `MPCR_OFF_DRV_HI:  qf_code = `MPCR_QF_DRV_HI;
      `MPCR_OFF_DEV_LO:  qf_code = `MPCR_QF_DEV_LO;
      `MPCR_OFF_DEV_HI:  qf_code = `MPCR_QF_DEV_HI;
      default:           qf_hit  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Per-queue storage; writes to an absent queue are dropped.
  mpcr_qmem u_qmem
  (
    .core_clk  (core_clk),
    .core_ce   (core_ce),
    .wr_en     (ctl_wr && qf_hit && q_exists && !soft_rst),
    .wr_queue  (qidx),
    .wr_field  (qf_code),
    .wr_data   (reg_wdata),
    .rd_en     (eng_rd),
    .rd_queue  (eng_queue),
    .rd_field  (eng_field),
    .rd_data_q (eng_data_q)
  );

  // Device-specific configuration space.
  mpcr_cfgmem u_cfgmem
  (
    .core_clk     (core_clk),
    .core_ce      (core_ce),
    .host_wr      (cfg_wr),
    .host_rd      (cfg_rd),
    .host_be      (reg_be),
    .host_idx     (reg_addr[`MPCR_CFG_IDX_W+1:2]),
    .host_wdata   (reg_wdata),
    .host_rdata_q (cfg_rdata_q),
    .dev_wr       (cfg_dev_wr),
    .dev_be       (cfg_dev_be),
    .dev_idx      (cfg_dev_idx),
    .dev_wdata    (cfg_dev_wdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Selectors, accepted features and status.
  always @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      off_sel_q           <= {`MPCR_DATA_W{1'b0}};
      acc_sel_q           <= {`MPCR_DATA_W{1'b0}};
      qsel_q              <= {`MPCR_DATA_W{1'b0}};
      accepted_features_q <= {`MPCR_FEAT_W{1'b0}};
      device_status_q     <= {`MPCR_DATA_W{1'b0}};
    end
    else if (core_ce && ctl_wr)
    begin
      case (reg_addr)
        `MPCR_OFF_OFF_SEL: off_sel_q <= reg_wdata;
        `MPCR_OFF_ACC_SEL: acc_sel_q <= reg_wdata;
        `MPCR_OFF_QSEL:    qsel_q    <= reg_wdata;
        `MPCR_OFF_STATUS:  device_status_q <= reg_wdata;
        `MPCR_OFF_ACCEPTED:
        begin
          if (acc_sel_q < `MPCR_FEAT_WINS)
            accepted_features_q[acc_sel_q[0]*`MPCR_DATA_W +: `MPCR_DATA_W] <= reg_wdata;
        end
        default:
        begin
          device_status_q <= device_status_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Queue enables and queue kicks.
  always @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      queue_enables_q <= {`MPCR_NUM_Q{1'b0}};
      kick_valid_q    <= 1'b0;
      kick_queue_q    <= {`MPCR_DATA_W{1'b0}};
    end
    else if (core_ce)
    begin
      kick_valid_q <= ctl_wr && (reg_addr == `MPCR_OFF_KICK);
      if (ctl_wr && (reg_addr == `MPCR_OFF_KICK))
        kick_queue_q <= reg_wdata;
      if (ctl_wr && (reg_addr == `MPCR_OFF_QENABLE) && q_exists)
        queue_enables_q[qidx] <= reg_wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event flags; a new event wins over an acknowledge in the same cycle.
  assign evt_set = {cfg_dev_wr, used_buffer_evt};
  assign evt_clr = (ctl_wr && (reg_addr == `MPCR_OFF_EVCLEAR)) ?
                   reg_wdata[`MPCR_EVT_W-1:0] : {`MPCR_EVT_W{1'b0}};

  always @*
  begin
    evt_d = (evt_q & ~evt_clr) | evt_set;
  end

  always @(posedge core_clk)
  begin
    if (rst || soft_rst)
    begin
      evt_q <= {`MPCR_EVT_W{1'b0}};
      irq_q <= 1'b0;
    end
    else if (core_ce)
    begin
      evt_q <= evt_d;
      irq_q <= |evt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Version counter moves on every device-side configuration change.
  always @(posedge core_clk)
  begin
    if (rst)
      version_q <= {`MPCR_DATA_W{1'b0}};
    else if (core_ce && cfg_dev_wr)
      version_q <= version_q + 32'h0000_0001;
  end

  // Device reset strobe for the rest of the device.
  always @(posedge core_clk)
  begin
    if (rst)
      dev_reset_pulse_q <= 1'b0;
    else if (core_ce)
      dev_reset_pulse_q <= soft_rst;
  end

  ////////////////////////////////////////////////////////////////////
  // Read value of the control region; anything else reads zero.
  always @*
  begin
    rd_imm_d = {`MPCR_DATA_W{1'b0}};
    case (reg_addr)
      `MPCR_OFF_OFFERED:
      begin
        if (off_sel_q < `MPCR_FEAT_WINS)
          rd_imm_d = offered_features_in[off_sel_q[0]*`MPCR_DATA_W +: `MPCR_DATA_W];
      end
      `MPCR_OFF_QLIMIT:
      begin
        if (q_exists)
          rd_imm_d = `MPCR_QSIZE_MAX;
      end
      `MPCR_OFF_QENABLE:
      begin
        if (q_exists)
          rd_imm_d = {31'h0000_0000, queue_enables_q[qidx]};
      end
      `MPCR_OFF_EVFLAGS: rd_imm_d = {30'h0000_0000, evt_q};
      `MPCR_OFF_STATUS:  rd_imm_d = device_status_q;
      `MPCR_OFF_VERSION: rd_imm_d = version_q;
      default:           rd_imm_d = {`MPCR_DATA_W{1'b0}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Two-stage read pipeline: capture, then registered answer.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_p1_q      <= 1'b0;
      rd_src_q     <= SRC_IMM;
      rd_imm_q     <= {`MPCR_DATA_W{1'b0}};
      reg_rvalid_q <= 1'b0;
      reg_rdata_q  <= {`MPCR_DATA_W{1'b0}};
    end
    else if (core_ce)
    begin
      rd_p1_q      <= reg_rd;
      rd_src_q     <= cfg_rd ? SRC_CFG : SRC_IMM;
      rd_imm_q     <= ctl_rd ? rd_imm_d : {`MPCR_DATA_W{1'b0}};
      reg_rvalid_q <= rd_p1_q;
      if (rd_p1_q)
        reg_rdata_q <= (rd_src_q == SRC_CFG) ? cfg_rdata_q : rd_imm_q;
    end
  end

endmodule

// ---- verilog/mpcr_defines.vh ----
// Constants for the paravirtual device control register bank.
`ifndef MPCR_DEFINES_VH
`define MPCR_DEFINES_VH

`define MPCR_ADDR_W        9
`define MPCR_DATA_W        32
`define MPCR_OFF_OFFERED   9'h010
`define MPCR_OFF_OFF_SEL   9'h014
`define MPCR_OFF_ACCEPTED  9'h020
`define MPCR_OFF_ACC_SEL   9'h024
`define MPCR_OFF_QSEL      9'h030
`define MPCR_OFF_QLIMIT    9'h034
`define MPCR_OFF_QSIZE     9'h038
`define MPCR_OFF_QENABLE   9'h044
`define MPCR_OFF_KICK      9'h050
`define MPCR_OFF_EVFLAGS   9'h060
`define MPCR_OFF_EVCLEAR   9'h064
`define MPCR_OFF_STATUS    9'h070
`define MPCR_OFF_DESC_LO   9'h080
`define MPCR_OFF_DESC_HI   9'h084
`define MPCR_OFF_DRV_LO    9'h090
`define MPCR_OFF_DRV_HI    9'h094
`define MPCR_OFF_DEV_LO    9'h0a0
`define MPCR_OFF_DEV_HI    9'h0a4
`define MPCR_OFF_VERSION   9'h0fc
`define MPCR_CFG_BIT       8
`define MPCR_NUM_Q         32'h0000_0004
`define MPCR_QIDX_W        2
`define MPCR_QSIZE_MAX     32'h0000_0100
`define MPCR_FEAT_W        64
`define MPCR_FEAT_WINS     32'h0000_0002
`define MPCR_EVT_W         2
`define MPCR_EVT_USED      0
`define MPCR_EVT_CFG       1
`define MPCR_QF_W          3
`define MPCR_QF_SIZE       3'h0
`define MPCR_QF_DESC_LO    3'h1
`define MPCR_QF_DESC_HI    3'h2
`define MPCR_QF_DRV_LO     3'h3
`define MPCR_QF_DRV_HI     3'h4
`define MPCR_QF_DEV_LO     3'h5
`define MPCR_QF_DEV_HI     3'h6
`define MPCR_CFG_IDX_W     6
`define MPCR_CFG_WORDS     64

`endif

// ---- verilog/mpcr_qmem.v ----
// Per-queue storage for size and the three area address halves.
`timescale 1ns/1ps
`include "mpcr_defines.vh"

module mpcr_qmem
(
  // Clock and enable.
  input  wire                                  core_clk,
  input  wire                                  core_ce,
  // Register side write port.
  input  wire                                  wr_en,
  input  wire [`MPCR_QIDX_W-1:0]               wr_queue,
  input  wire [`MPCR_QF_W-1:0]                 wr_field,
  input  wire [`MPCR_DATA_W-1:0]               wr_data,
  // Queue engine read port.
  input  wire                                  rd_en,
  input  wire [`MPCR_QIDX_W-1:0]               rd_queue,
  input  wire [`MPCR_QF_W-1:0]                 rd_field,
  output reg  [`MPCR_DATA_W-1:0]               rd_data_q
);

  reg [`MPCR_DATA_W-1:0] mem [0:(1<<(`MPCR_QIDX_W+`MPCR_QF_W))-1];

  ////////////////////////////////////////////////////////////////////
  // One word per queue and field; read data leave through a register.
  always @(posedge core_clk)
  begin
    if (core_ce)
    begin
      if (wr_en)
        mem[{wr_queue, wr_field}] <= wr_data;
      if (rd_en)
        rd_data_q <= mem[{rd_queue, rd_field}];
    end
  end

endmodule

// ---- verilog/mpcr_cfgmem.v ----
// Device-specific configuration space with byte lanes.
`timescale 1ns/1ps
`include "mpcr_defines.vh"

module mpcr_cfgmem
(
  // Clock and enable.
  input  wire                                  core_clk,
  input  wire                                  core_ce,
  // Host side port.
  input  wire                                  host_wr,
  input  wire                                  host_rd,
  input  wire [3:0]                            host_be,
  input  wire [`MPCR_CFG_IDX_W-1:0]            host_idx,
  input  wire [`MPCR_DATA_W-1:0]               host_wdata,
  output reg  [`MPCR_DATA_W-1:0]               host_rdata_q,
  // Device side write port.
  input  wire                                  dev_wr,
  input  wire [3:0]                            dev_be,
  input  wire [`MPCR_CFG_IDX_W-1:0]            dev_idx,
  input  wire [`MPCR_DATA_W-1:0]               dev_wdata
);

  reg [`MPCR_DATA_W-1:0] mem [0:`MPCR_CFG_WORDS-1];
  integer                lane;

  ////////////////////////////////////////////////////////////////////
  // Byte lanes written separately; the device lane wins on a collision.
  always @(posedge core_clk)
  begin
    if (core_ce)
    begin
      for (lane = 0; lane < 4; lane = lane + 1)
      begin
        if (host_wr && host_be[lane])
          mem[host_idx][lane*8 +: 8] <= host_wdata[lane*8 +: 8];
        if (dev_wr && dev_be[lane])
          mem[dev_idx][lane*8 +: 8] <= dev_wdata[lane*8 +: 8];
      end
      if (host_rd)
        host_rdata_q <= mem[host_idx];
    end
  end

endmodule

// ---- test/mpcr_regs_asserts.sv ----
// Concurrent checks on the control register bank ports.
`timescale 1ns/1ps
`include "mpcr_defines.vh"
module mpcr_regs_asserts
(
  // Clock and reset.
  input wire                    core_clk,
  input wire                    rst,
  input wire                    core_ce,
  // Register port.
  input wire [`MPCR_ADDR_W-1:0] reg_addr,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [`MPCR_DATA_W-1:0] reg_wdata,
  input wire                    reg_rvalid_q,
  // Device side.
  input wire [`MPCR_FEAT_W-1:0] accepted_features_q,
  input wire [`MPCR_NUM_Q-1:0]  queue_enables_q,
  input wire                    kick_valid_q,
  input wire [`MPCR_DATA_W-1:0] kick_queue_q,
  input wire                    used_buffer_evt,
  input wire                    cfg_dev_wr,
  input wire [`MPCR_DATA_W-1:0] device_status_q,
  input wire                    dev_reset_pulse_q,
  input wire                    irq_q
);
  wire wr_go = reg_wr && core_ce;
  wire clr = wr_go && reg_addr == `MPCR_OFF_EVCLEAR;
  wire st_go = wr_go && reg_addr == `MPCR_OFF_STATUS;
  wire szr = st_go && reg_wdata == 32'h0000_0000;
  wire evt = core_ce && (used_buffer_evt || cfg_dev_wr);
  wire en_go = st_go || (wr_go && reg_addr == `MPCR_OFF_QENABLE);
  wire acc_go = st_go || (wr_go && reg_addr == `MPCR_OFF_ACCEPTED);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_used_sets_irq: assert property (core_ce && used_buffer_evt && !szr |=> irq_q)
    else $error("Interrupt missing after a used buffer event.");
  a_cfg_sets_irq: assert property (core_ce && cfg_dev_wr && !szr |=> irq_q)
    else $error("Interrupt missing after a configuration change.");
  a_irq_holds: assert property (irq_q && !clr && !szr && !$past(clr) && !$past(szr) |=> irq_q)
    else $error("Interrupt dropped without an acknowledge.");
  a_irq_has_cause: assert property ($rose(irq_q) |-> $past(evt) || $past(evt, 2))
    else $error("Interrupt rose without an event.");
  a_kick_pulse: assert property (wr_go && reg_addr == `MPCR_OFF_KICK |=> kick_valid_q && kick_queue_q == $past(reg_wdata))
    else $error("Kick write not passed on.");
  a_soft_clears: assert property (szr |=> device_status_q == 32'h0000_0000 && queue_enables_q == 4'h0 && !irq_q)
    else $error("Zero status write left state behind.");
  a_reset_pulse: assert property (szr |-> ##[1:2] dev_reset_pulse_q)
    else $error("No device reset pulse after zero status write.");
  a_status_write: assert property (st_go && reg_wdata != 32'h0000_0000 |=> device_status_q == $past(reg_wdata))
    else $error("Status write not recorded.");
  a_enable_src: assert property (!$stable(queue_enables_q) |-> $past(en_go))
    else $error("Queue enables changed without a write.");
  a_accept_src: assert property (!$stable(accepted_features_q) |-> $past(acc_go))
    else $error("Accepted features changed without a write.");
  a_read_answer: assert property (reg_rd && core_ce |-> ##2 reg_rvalid_q)
    else $error("Read not answered two cycles later.");
endmodule

// ---- test/mpcr_host.sv ----
// Host processor model issuing register reads and writes.
`timescale 1ns/1ps
`include "mpcr_defines.vh"
module mpcr_host
(
  // Clock.
  input  wire                    core_clk,
  // Register port.
  output reg  [`MPCR_ADDR_W-1:0] reg_addr,
  output reg                     reg_wr,
  output reg                     reg_rd,
  output reg  [3:0]              reg_be,
  output reg  [`MPCR_DATA_W-1:0] reg_wdata,
  input  wire [`MPCR_DATA_W-1:0] reg_rdata_q,
  input  wire                    reg_rvalid_q
);
  integer n;
  integer late_count = 0;
  initial
  begin
    reg_addr = 9'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 4'hf;
    reg_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid_q !== 1'b1 && n < 4)
    begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
    if (reg_rvalid_q !== 1'b1)
      late_count = late_count + 1;
    d = reg_rdata_q;
  endtask
endmodule

// ---- test/test_mpcr_regs.sv ----
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
`include "mpcr_defines.vh"
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module test_mpcr_regs;
  logic        core_clk = 1'b0;
  logic        core_ce = 1'b1;
  logic        rst = 1'b1;
  logic        eng_rd = 1'b0;
  logic [1:0]  eng_queue = 2'h0;
  logic [2:0]  eng_field = 3'h0;
  logic        used_buffer_evt = 1'b0;
  logic        cfg_dev_wr = 1'b0;
  logic [31:0] cfg_dev_wdata = 32'h5a5a_0001;
  logic [31:0] v0;
  logic [31:0] v1;
  logic [8:0]  qoff [7] = '{9'h038, 9'h080, 9'h084, 9'h090, 9'h094, 9'h0a0, 9'h0a4};
  int          err_total = 0;
  int          check_count = 0;
  int          i;
  int          k;
  wire  [8:0]  reg_addr;
  wire         reg_wr, reg_rd, reg_rvalid_q, kick_valid_q, dev_reset_pulse_q, irq_q;
  wire  [3:0]  reg_be, queue_enables_q;
  wire  [31:0] reg_wdata, reg_rdata_q, kick_queue_q, eng_data_q, device_status_q;
  wire  [63:0] accepted_features_q;
  mpcr_regs u_dut (.core_clk, .rst, .core_ce, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q, .offered_features_in(64'h0123_4567_89ab_cdef), .accepted_features_q,
    .queue_enables_q, .kick_valid_q, .kick_queue_q, .eng_rd, .eng_queue, .eng_field, .eng_data_q,
    .used_buffer_evt, .cfg_dev_wr, .cfg_dev_be(4'hf), .cfg_dev_idx(6'h00), .cfg_dev_wdata,
    .device_status_q, .dev_reset_pulse_q, .irq_q);
  mpcr_host u_host (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata_q, .reg_rvalid_q);
  always #2 core_clk = ~core_clk;
  task automatic rdc(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    u_host.wr(a, d, 4'hf);
  endtask
  task automatic eng(input int q, input int f);
    @(posedge core_clk);
    #1;
    eng_queue = q[1:0];
    eng_field = f[2:0];
    eng_rd = 1'b1;
    @(posedge core_clk);
    #1;
    eng_rd = 1'b0;
    `CHK(eng_data_q, 32'h00a0_0000 + 32'(q * 16 + f))
  endtask
  task automatic ev(input logic u, input logic c);
    @(posedge core_clk);
    #1;
    used_buffer_evt = u;
    cfg_dev_wr = c;
    @(posedge core_clk);
    #1;
    used_buffer_evt = 1'b0;
    cfg_dev_wr = 1'b0;
  endtask
  task end_sim;
    err_total += u_host.late_count;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    err_total++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0000);
    rdc(`MPCR_OFF_QENABLE, 32'h0000_0000);
    rdc(9'h0c0, 32'h0000_0000);
    $display("test reset done");
    wr(`MPCR_OFF_OFF_SEL, 32'h0000_0001);
    rdc(`MPCR_OFF_OFF_SEL, 32'h0000_0000);
    rdc(`MPCR_OFF_OFFERED, 32'h0123_4567);
    wr(`MPCR_OFF_OFF_SEL, 32'h0000_0000);
    rdc(`MPCR_OFF_OFFERED, 32'h89ab_cdef);
    wr(`MPCR_OFF_OFF_SEL, 32'h0000_0002);
    rdc(`MPCR_OFF_OFFERED, 32'h0000_0000);
    wr(`MPCR_OFF_ACC_SEL, 32'h0000_0001);
    wr(`MPCR_OFF_ACCEPTED, 32'h1234_5678);
    wr(`MPCR_OFF_ACC_SEL, 32'h0000_0000);
    wr(`MPCR_OFF_ACCEPTED, 32'h9abc_def0);
    `CHK(accepted_features_q, 64'h1234_5678_9abc_def0)
    $display("test features done");
    for (i = 0; i < 4; i++)
    begin
      wr(`MPCR_OFF_QSEL, 32'(i));
      for (k = 0; k < 7; k++)
        wr(qoff[k], 32'h00a0_0000 + 32'(i * 16 + k));
      wr(`MPCR_OFF_QENABLE, 32'(i % 2));
    end
    for (i = 0; i < 4; i++)
    begin
      wr(`MPCR_OFF_QSEL, 32'(i));
      rdc(`MPCR_OFF_QLIMIT, `MPCR_QSIZE_MAX);
      rdc(`MPCR_OFF_QENABLE, 32'(i % 2));
      for (k = 0; k < 7; k++)
        eng(i, k);
    end
    `CHK(queue_enables_q, 4'b1010)
    wr(`MPCR_OFF_QLIMIT, 32'h0000_0007);
    rdc(`MPCR_OFF_QLIMIT, `MPCR_QSIZE_MAX);
    wr(`MPCR_OFF_QSEL, 32'h0000_0004);
    rdc(`MPCR_OFF_QLIMIT, 32'h0000_0000);
    $display("test queues done");
    wr(`MPCR_OFF_KICK, 32'h0000_0002);
    `CHK(kick_valid_q, 1'b1)
    `CHK(kick_queue_q, 32'h0000_0002)
    $display("test kick done");
    u_host.rd(`MPCR_OFF_VERSION, v0);
    ev(1'b1, 1'b0);
    `CHK(irq_q, 1'b1)
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0001);
    ev(1'b0, 1'b1);
    u_host.rd(`MPCR_OFF_VERSION, v1);
    `CHK(v1, v0 + 32'h0000_0001)
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0003);
    rdc(9'h100, 32'h5a5a_0001);
    wr(`MPCR_OFF_EVCLEAR, 32'h0000_0001);
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0002);
    `CHK(irq_q, 1'b1)
    wr(`MPCR_OFF_EVCLEAR, 32'h0000_0002);
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0000);
    `CHK(irq_q, 1'b0)
    $display("test events done");
    u_host.wr(9'h104, 32'h1122_3344, 4'hf);
    u_host.wr(9'h104, 32'haaaa_bbbb, 4'h3);
    rdc(9'h104, 32'h1122_bbbb);
    u_host.rd(`MPCR_OFF_VERSION, v0);
    `CHK(v0, v1)
    $display("test config done");
    wr(`MPCR_OFF_STATUS, 32'h0000_000f);
    rdc(`MPCR_OFF_STATUS, 32'h0000_000f);
    ev(1'b1, 1'b0);
    wr(`MPCR_OFF_STATUS, 32'h0000_0000);
    rdc(`MPCR_OFF_STATUS, 32'h0000_0000);
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0000);
    `CHK(queue_enables_q, 4'h0)
    `CHK(irq_q, 1'b0)
    core_ce = 1'b0;
    ev(1'b1, 1'b0);
    wr(`MPCR_OFF_STATUS, 32'h0000_0003);
    `CHK(irq_q, 1'b0)
    core_ce = 1'b1;
    rdc(`MPCR_OFF_EVFLAGS, 32'h0000_0000);
    rdc(`MPCR_OFF_STATUS, 32'h0000_0000);
    $display("test status done");
    end_sim;
  end
endmodule
bind mpcr_regs mpcr_regs_asserts u_chk (.core_clk, .rst, .core_ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rvalid_q, .accepted_features_q, .queue_enables_q, .kick_valid_q, .kick_queue_q, .used_buffer_evt,
  .cfg_dev_wr, .device_status_q, .dev_reset_pulse_q, .irq_q);
